// file: include/rpv_pkg.sv
// shared constants and state type for the raster plane readout and video map
package rpv_pkg;

  // plane storage geometry
  localparam int unsigned WORDS     = 16384;
  localparam int unsigned WORD_W    = 20;
  localparam int unsigned ADDR_W    = 14;
  localparam int unsigned GROUPS    = 4;
  localparam int unsigned GROUP_SZ  = 5;
  localparam int unsigned RB_W      = 24;
  localparam logic [4:0]  LAST_DOT  = 5'h13;  // twentieth dot of a word

  // brightness map geometry
  localparam int unsigned MAP_DEPTH = 16;
  localparam int unsigned MAP_W     = 4;

  // cycle mode codes as {cycle_sel_hi_n, cycle_sel_lo_n}
  localparam logic [1:0] MODE_VECTOR  = 2'h0;
  localparam logic [1:0] MODE_BLOCK   = 2'h1;
  localparam logic [1:0] MODE_READ    = 2'h2;  // lo line 0, hi line 1
  localparam logic [1:0] MODE_REFRESH = 2'h3;

  // register byte offsets on the axi4-lite port
  localparam logic [7:0] OFF_WE      = 8'h00;
  localparam logic [7:0] OFF_BORDER  = 8'h04;
  localparam logic [7:0] OFF_RB_LO   = 8'h08;
  localparam logic [7:0] OFF_RB_HI   = 8'h0C;
  localparam logic [7:0] OFF_MAP     = 8'h40;
  localparam logic [7:0] MAP_WIN_MSK = 8'hC0;

  // i/o window of the two-plane variant
  localparam logic [15:0] DUAL_IO_LO = 16'hF7E0;
  localparam logic [15:0] DUAL_IO_HI = 16'hF7F7;

  // reset values
  localparam logic        WE_RST     = 1'b0;
  localparam logic        BORDER_RST = 1'b1;
  localparam logic [63:0] MAP_RST    = 64'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        write_permit;
    logic        edge_blank;
    logic [23:0] readback;
    logic [19:0] shift;
    logic [4:0]  dot_cnt;
    logic        sync_pix_n;
    logic        sync_oe;
    logic [63:0] map;
    logic [3:0]  intensity;
    logic [3:0]  we_grp_n;
    logic [3:0]  cas_grp_n;
  } rpv_state_s;

endpackage

// file: src/rpv_top.sv
// raster plane storage, read-back latches, video shifter and brightness map
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - plane is 16k words, one array per bit
// - per-bit row strobes, grouped write and column strobes
// - column strobe in read cycle loads read-back
// - read-back holds 20 pixels plus 4 test bits
// - two selects return read-back as low 16 and top 8 bits
// - test bits: permit, video, border, zero
// - decoder makes two reads, two writes, map write
// - shifter loads word at each refresh cycle
// - serial bit retimed by a dot clock flop
// - map write clears and floats the retimer
// - border latch blanks both line edges
// - map is 16 by 4 indexed by planes, cursor
// - lone standard plane uses index 0000 or 0100
// - map output registered onto intensity lines
// - i/o address selects map index, switches selector
// - map write needs all four strobes low
// - two-plane variant drops the map
module rpv_top #(
  parameter bit DUAL_PLANE = 1'b0
) (
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  // axi4-lite write address and data
  input  wire logic [7:0]           s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]           s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  // vector generator cycle control
  input  wire logic                 cycle_sel_lo_n_i,
  input  wire logic                 cycle_sel_hi_n_i,
  input  wire logic                 col_strobe_i,
  input  wire logic [13:0]          mem_addr_i,
  input  wire logic [19:0]          mem_wdata_i,
  input  wire logic [19:0]          row_strobe_n_i,
  // ram control strobes toward the array groups
  output logic [3:0]                write_en_group_n_o,
  output logic [3:0]                col_strobe_group_n_o,
  // line timing for the border latch
  input  wire logic                 line_blank_i,
  input  wire logic                 active_start_i,
  input  wire logic                 active_end_i,
  // other planes and cursor
  input  wire logic                 plane0_pixel_i,
  input  wire logic                 plane1_pixel_i,
  input  wire logic                 cursor_i,
  // serial video and intensity lines
  output logic                      plane2_serial_pixel_n_o,
  output logic                      plane2_serial_pixel_oe_o,
  output logic [3:0]                intensity_line_o
);

  rpv_pkg::rpv_state_s st_r;
  rpv_pkg::rpv_state_s st_nxt;
  logic [1:0]          rst_sync_r;
  logic                rst_n;
  logic [19:0]         rd_word;
  logic [19:0]         bit_we;
  logic [1:0]          mode;
  logic                rd_cycle;

  // timing at a glance, in dot clocks:
  //   bus write: both channels held, next edge commits and raises the response
  //   bus read: data and response load on the edge that takes the address
  //   read cycle: latches load on the edge that sees the column strobe
  //   refresh: shifter loads, serial bit one edge on, intensity one more
  //   map write: retimer floats on the commit edge, back one edge on
  //   border: pulses act on the edge that samples them
  // bus side and array side share the dot clock, so a register write
  // lands between two dots and needs no crossing logic

  // reset is released through two flops; assertion is immediate, but
  // release waits for the clock so no flop sees rst_n_i move near an edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // the two cycle lines arrive as a level code for the whole cycle;
  // only the column strobe marks the edge on which that code acts
  assign mode     = {cycle_sel_hi_n_i, cycle_sel_lo_n_i};
  assign rd_cycle = (mode == rpv_pkg::MODE_READ);

  // per-bit write: only when permitted, never in a read cycle
  // the permit flag is software's master switch for drawing
  // block cycles are ignored here; their pixel path lives outside
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      bit_we[i] = col_strobe_i && !row_strobe_n_i[i]
                  && (mode == rpv_pkg::MODE_VECTOR)
                  && st_r.write_permit && !rd_cycle;
    end
  end

  // twenty one-bit arrays, one bit position each; no reset on storage
  // a real array powers up holding junk, so nothing may rely on a
  // cleared word; reads are combinational so latch and shifter can
  // take the word on the same edge as the strobe
  for (genvar g = 0; g < 20; g++) begin : g_bit
    logic bit_mem [rpv_pkg::WORDS];
    always_ff @(posedge sys_clk_i) begin
      if (bit_we[g]) begin
        bit_mem[mem_addr_i] <= mem_wdata_i[g];
      end
    end
    assign rd_word[g] = bit_mem[mem_addr_i];
  end

  // next-state logic for bus slave, latches, shifter and map
  always_comb begin
    logic       aw_hs;
    logic       w_hs;
    logic       wr_go;
    logic       io_wr_n;
    logic       aux_wr_n;
    logic       vg_sel_n;
    logic       a10_n;
    logic       map_wr;
    logic [3:0] io_idx;
    logic [3:0] pix_idx;
    logic       pix;
    logic [7:0] ra;
    aw_hs    = 1'b0;
    w_hs     = 1'b0;
    wr_go    = 1'b0;
    io_wr_n  = 1'b1;
    aux_wr_n = 1'b1;
    vg_sel_n = 1'b1;
    a10_n    = 1'b1;
    map_wr   = 1'b0;
    io_idx   = 4'h0;
    pix_idx  = 4'h0;
    pix      = 1'b0;
    ra       = s_axi_araddr_i;
    st_nxt   = st_r;

    // write channels taken in either order
    // each channel is held in its own slot until the pair is complete
    aw_hs = s_axi_awvalid_i && st_r.awready;
    w_hs  = s_axi_wvalid_i && st_r.wready;
    if (aw_hs) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr_i;
    end
    if (w_hs) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata_i;
      st_nxt.w_strb = s_axi_wstrb_i;
    end
    if (st_r.bvalid && s_axi_bready_i) begin
      st_nxt.bvalid = 1'b0;
    end
    wr_go = st_r.aw_got && st_r.w_got && !st_r.bvalid;

    // i/o decode: any write pulls io_wr_n low; the map window pulls the other three low, a10 only when DUAL_PLANE is off
    // the strobes stay separate active-low terms so the map write
    // reads as a plain four-way coincidence
    if (wr_go) begin
      io_wr_n = 1'b0;
      if ((st_r.aw_addr & rpv_pkg::MAP_WIN_MSK) == rpv_pkg::OFF_MAP) begin
        aux_wr_n = 1'b0;
        vg_sel_n = 1'b0;
        a10_n    = DUAL_PLANE;
      end
    end
    io_idx = st_r.aw_addr[5:2];
    map_wr = !io_wr_n && !aux_wr_n && !vg_sel_n && !a10_n;

    // register writes complete with one response
    // unused strobe lanes are ignored: every field sits in byte lane 0
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = rpv_pkg::RESP_OKAY;
      if (map_wr) begin
        if (st_r.w_strb[0]) begin
          st_nxt.map[io_idx*4 +: 4] = st_r.w_data[3:0];
        end
      end else if ((st_r.aw_addr & rpv_pkg::MAP_WIN_MSK)
                   == rpv_pkg::OFF_MAP) begin
        // two-plane variant has no map: the write is accepted and lost
        st_nxt.bresp = rpv_pkg::RESP_OKAY;
      end else if (st_r.aw_addr == rpv_pkg::OFF_WE) begin
        if (st_r.w_strb[0]) begin
          st_nxt.write_permit = st_r.w_data[0];
        end
      end else if (st_r.aw_addr == rpv_pkg::OFF_BORDER) begin
        if (st_r.w_strb[0]) begin
          st_nxt.edge_blank = st_r.w_data[0];
        end
      end else begin
        st_nxt.bresp = rpv_pkg::RESP_SLVERR;
      end
    end

    // register reads: one cycle from address to data
    // read data is built from registered state only, so rdata never
    // carries a combinational path from the array
    if (st_r.rvalid && s_axi_rready_i) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = rpv_pkg::RESP_OKAY;
      st_nxt.rdata  = 32'h0;
      if ((ra & rpv_pkg::MAP_WIN_MSK) == rpv_pkg::OFF_MAP && !DUAL_PLANE) begin
        st_nxt.rdata[3:0] = st_r.map[ra[5:2]*4 +: 4];
      end else if (ra == rpv_pkg::OFF_WE) begin
        st_nxt.rdata[0] = st_r.write_permit;
      end else if (ra == rpv_pkg::OFF_BORDER) begin
        st_nxt.rdata[0] = st_r.edge_blank;
      end else if (ra == rpv_pkg::OFF_RB_LO) begin
        st_nxt.rdata[15:0] = st_r.readback[15:0];
      end else if (ra == rpv_pkg::OFF_RB_HI) begin
        st_nxt.rdata[7:0] = st_r.readback[23:16];
      end else begin
        st_nxt.rresp = rpv_pkg::RESP_SLVERR;
      end
    end

    // read cycle: capture raw array output, no pixel logic in the path
    if (rd_cycle && col_strobe_i) begin
      st_nxt.readback[19:0] = rd_word;
    end
    // live test bits beside the top pixel bits; the video bit is shown
    // active high even though the pin that carries it is active low
    st_nxt.readback[23:20] = {1'b0, st_r.edge_blank,
                              !st_r.sync_pix_n, st_r.write_permit};

    // shifter: load at refresh, then one bit per dot
    // dot_cnt parks on the last dot, so a late refresh leaves it
    // stuck there instead of wrapping into a false word boundary
    if (mode == rpv_pkg::MODE_REFRESH && col_strobe_i) begin
      st_nxt.shift   = rd_word;
      st_nxt.dot_cnt = 5'h0;
    end else begin
      st_nxt.shift = {1'b0, st_r.shift[19:1]};
      if (st_r.dot_cnt != rpv_pkg::LAST_DOT) begin
        st_nxt.dot_cnt = st_r.dot_cnt + 5'h1;
      end
    end

    // retime; a map write clears the flop and floats its output, so the
    // pixel path cannot fight the processor index on the map address
    // the flop holds the pin level, active low, so the pin has no gate
    st_nxt.sync_pix_n = map_wr ? 1'b1 : !st_r.shift[0];
    st_nxt.sync_oe  = !map_wr;

    // border latch: blanking pulse sets, active video clears
    // the hardware terms come after the software write above, so a
    // blanking pulse wins over a register write in the same cycle
    if (line_blank_i || active_end_i) begin
      st_nxt.edge_blank = 1'b1;
    end else if (active_start_i) begin
      st_nxt.edge_blank = 1'b0;
    end

    // map lookup; plane 2 sits on index bit 2
    // the other planes and cursor come in as levels on this clock
    pix     = !st_r.sync_pix_n && !st_r.edge_blank;
    pix_idx = {cursor_i, pix, plane1_pixel_i, plane0_pixel_i};
    if (DUAL_PLANE) begin
      st_nxt.intensity = {4{pix}};
    end else begin
      st_nxt.intensity = st_r.map[pix_idx*4 +: 4];
    end

    // grouped strobes toward the array, writes held off in read cycles
    // a group write enable falls if any of its five bits is written
    st_nxt.cas_grp_n = {4{!col_strobe_i}};
    for (int k = 0; k < 4; k++) begin
      st_nxt.we_grp_n[k] = !(|bit_we[k*5 +: 5]);
    end

    // ready flags follow the channel state
    // taken from the next state so a channel never looks ready on the
    // edge right after it was filled
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
  end

  // single state register; fields with a non-zero idle level are
  // named after the blanket clear
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r              <= '0;
      st_r.write_permit <= rpv_pkg::WE_RST;
      st_r.edge_blank   <= rpv_pkg::BORDER_RST;
      st_r.map          <= rpv_pkg::MAP_RST;
      st_r.dot_cnt      <= rpv_pkg::LAST_DOT;
      st_r.sync_oe      <= 1'b1;
      st_r.sync_pix_n   <= 1'b1;
      st_r.we_grp_n     <= 4'hF;
      st_r.cas_grp_n    <= 4'hF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  // every pin below is a bare flop output; inversions live in the
  // state so no glitch can reach the pins
  assign s_axi_awready_o          = st_r.awready;
  assign s_axi_wready_o           = st_r.wready;
  assign s_axi_bvalid_o           = st_r.bvalid;
  assign s_axi_bresp_o            = st_r.bresp;
  assign s_axi_arready_o          = st_r.arready;
  assign s_axi_rvalid_o           = st_r.rvalid;
  assign s_axi_rdata_o            = st_r.rdata;
  assign s_axi_rresp_o            = st_r.rresp;
  assign write_en_group_n_o       = st_r.we_grp_n;
  assign col_strobe_group_n_o     = st_r.cas_grp_n;
  assign plane2_serial_pixel_n_o  = st_r.sync_pix_n;
  assign plane2_serial_pixel_oe_o = st_r.sync_oe;
  assign intensity_line_o         = st_r.intensity;

endmodule

// file: bench/rpv_top_checker.sv
// concurrent checks on the ports of the plane readout and video map
`timescale 1ns/1ps
module rpv_top_checker (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  // register bus
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  // array cycle and video
  input wire logic        cycle_sel_lo_n_i,
  input wire logic        cycle_sel_hi_n_i,
  input wire logic        col_strobe_i,
  input wire logic [3:0]  write_en_group_n_o,
  input wire logic [3:0]  col_strobe_group_n_o,
  input wire logic        plane2_serial_pixel_n_o,
  input wire logic        plane2_serial_pixel_oe_o
);
  logic [7:0] ar_r;

  // keep the taken read address so the answer can be judged by it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ar_r <= 8'h00;
    else if (s_axi_arvalid_i && s_axi_arready_o) ar_r <= s_axi_araddr_i;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_cas_follow: assert property (col_strobe_i |=>
    col_strobe_group_n_o == 4'h0) else $error("column strobes missed");
  a_cas_idle: assert property (!col_strobe_i |=>
    col_strobe_group_n_o == 4'hF) else $error("column strobe spurious");
  a_read_nowrite: assert property (
    col_strobe_i && !cycle_sel_lo_n_i && cycle_sel_hi_n_i |=>
    write_en_group_n_o == 4'hF) else $error("write during read cycle");
  a_b_taken: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
    !s_axi_bvalid_o) else $error("write response repeated");
  a_r_taken: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
    !s_axi_rvalid_o) else $error("read response repeated");
  a_aw_busy: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o) else $error("write address taken while busy");
  a_ar_busy: assert property (s_axi_rvalid_o |->
    !s_axi_arready_o) else $error("read address taken while busy");
  a_rb_upper: assert property (
    s_axi_rvalid_o && ar_r == rpv_pkg::OFF_RB_HI |->
    s_axi_rdata_o[31:7] == 25'h0) else $error("upper half not zero");
  a_unmapped_err: assert property (s_axi_rvalid_o && ar_r == 8'h10 |->
    s_axi_rresp_o == rpv_pkg::RESP_SLVERR) else $error("unmapped read ok");
  a_float_clear: assert property (!plane2_serial_pixel_oe_o |->
    plane2_serial_pixel_n_o) else $error("retimer not cleared");

  c_refresh: cover property (col_strobe_i && cycle_sel_lo_n_i
    && cycle_sel_hi_n_i);
  c_map_write: cover property (!plane2_serial_pixel_oe_o);
  c_slverr: cover property (s_axi_rvalid_o
    && s_axi_rresp_o == rpv_pkg::RESP_SLVERR);
endmodule

bind rpv_top rpv_top_checker u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .cycle_sel_lo_n_i(cycle_sel_lo_n_i), .cycle_sel_hi_n_i(cycle_sel_hi_n_i),
  .col_strobe_i(col_strobe_i), .write_en_group_n_o(write_en_group_n_o),
  .col_strobe_group_n_o(col_strobe_group_n_o),
  .plane2_serial_pixel_n_o(plane2_serial_pixel_n_o),
  .plane2_serial_pixel_oe_o(plane2_serial_pixel_oe_o));

// file: bench/rpv_vecgen_model.sv
// behavioural vector generator issuing plane cycles
`timescale 1ns/1ps
module rpv_vecgen_model (
  // clock
  input  wire logic   clk_i,
  // plane cycle lines
  output logic        cycle_sel_lo_n_o,
  output logic        cycle_sel_hi_n_o,
  output logic        col_strobe_o,
  output logic [13:0] mem_addr_o,
  output logic [19:0] mem_wdata_o,
  output logic [19:0] row_strobe_n_o
);
  // idle in block mode, which the array ignores
  initial begin
    {cycle_sel_hi_n_o, cycle_sel_lo_n_o} = rpv_pkg::MODE_BLOCK;
    col_strobe_o = 1'b0;
    mem_addr_o = 14'h0000;
    mem_wdata_o = 20'h00000;
    row_strobe_n_o = 20'hFFFFF;
  end

  // address a cycle ahead of mode and strobe; bus scrambled once done
  task automatic run(input logic [1:0] mode, input logic [13:0] a,
                     input logic [19:0] w);
    @(posedge clk_i);
    mem_addr_o <= a;
    mem_wdata_o <= w;
    row_strobe_n_o <= 20'h00000;
    @(posedge clk_i);
    {cycle_sel_hi_n_o, cycle_sel_lo_n_o} <= mode;
    col_strobe_o <= 1'b1;
    @(posedge clk_i);
    {cycle_sel_hi_n_o, cycle_sel_lo_n_o} <= rpv_pkg::MODE_BLOCK;
    col_strobe_o <= 1'b0;
    mem_addr_o <= ~a;
    mem_wdata_o <= ~w;
    row_strobe_n_o <= 20'hFFFFF;
  endtask
endmodule

// file: bench/rpv_top_tb_top.sv
// self-checking bench for the plane readout and video map
`timescale 1ns/1ps
module rpv_top_tb_top;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pix_n, oe;
  logic        lblank, astart, aend, lo_n, hi_n, cstr;
  logic [2:0]  side;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  we_n, cas_n, inten;
  logic [13:0] maddr;
  logic [19:0] mwdata, rows_n;
  int          mismatches, cmp_count;
  int          cyc = 0;
  int          float_cnt = 0;
  localparam logic [19:0] WORD = 20'h5A3C9;
  localparam logic [13:0] ADR = 14'h1234;

  rpv_vecgen_model vg (.clk_i(clk), .cycle_sel_lo_n_o(lo_n),
    .cycle_sel_hi_n_o(hi_n), .col_strobe_o(cstr), .mem_addr_o(maddr),
    .mem_wdata_o(mwdata), .row_strobe_n_o(rows_n));

  rpv_top dut (.sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .cycle_sel_lo_n_i(lo_n),
    .cycle_sel_hi_n_i(hi_n), .col_strobe_i(cstr), .mem_addr_i(maddr),
    .mem_wdata_i(mwdata), .row_strobe_n_i(rows_n),
    .write_en_group_n_o(we_n), .col_strobe_group_n_o(cas_n),
    .line_blank_i(lblank), .active_start_i(astart), .active_end_i(aend),
    .plane0_pixel_i(side[0]), .plane1_pixel_i(side[1]), .cursor_i(side[2]),
    .plane2_serial_pixel_n_o(pix_n), .plane2_serial_pixel_oe_o(oe),
    .intensity_line_o(inten));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard and float watch
  always @(posedge clk) begin
    cyc++;
    if (oe === 1'b0) float_cnt++;
    if (cyc > 20000) begin
      mismatches++;
      end_of_test;
    end
  end

  task automatic end_of_test;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // both write channels offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic t_reset;
    axi_rd(rpv_pkg::OFF_WE);
    check(rdv, 32'h0, "permit reset");
    axi_rd(rpv_pkg::OFF_BORDER);
    check(rdv, 32'h1, "border reset");
    axi_rd(8'h44);
    check(rdv, 32'h0, "map reset");
  endtask

  // unmapped and read-only places answer with an error
  task automatic t_errors;
    axi_rd(8'h10);
    check(resp, rpv_pkg::RESP_SLVERR, "unmapped read");
    axi_wr(rpv_pkg::OFF_RB_LO, 32'hFFFF);
    check(resp, rpv_pkg::RESP_SLVERR, "read-only write");
  endtask

  // write a word, read it back, then prove a refused write
  task automatic t_readback;
    axi_wr(rpv_pkg::OFF_WE, 32'h1);
    vg.run(rpv_pkg::MODE_VECTOR, ADR, WORD);
    vg.run(rpv_pkg::MODE_READ, ADR, ~WORD);
    axi_rd(rpv_pkg::OFF_RB_LO);
    check(rdv, {16'h0, WORD[15:0]}, "readback low");
    axi_rd(rpv_pkg::OFF_RB_HI);
    check(rdv, {24'h5, WORD[19:16]}, "test bits");
    axi_wr(rpv_pkg::OFF_WE, 32'h0);
    vg.run(rpv_pkg::MODE_VECTOR, ADR, ~WORD);
    vg.run(rpv_pkg::MODE_READ, ADR, 20'h00000);
    axi_rd(rpv_pkg::OFF_RB_LO);
    check(rdv, {16'h0, WORD[15:0]}, "write refused");
  endtask

  // each map write floats the retimer for exactly one cycle
  task automatic t_map;
    int n;
    n = float_cnt;
    axi_wr(rpv_pkg::OFF_MAP, 32'h2);
    axi_wr(8'h50, 32'hC);
    axi_wr(8'h54, 32'h9);
    axi_wr(8'h6C, 32'h7);
    axi_rd(8'h54);
    check(rdv, 32'h9, "map index five");
    check(float_cnt - n, 32'h4, "retimer floated");
    check(oe, 1'b1, "retimer driving");
    @(posedge clk);
    side <= 3'h7;
    @(posedge clk);
    #1;
    check(inten, 4'h7, "planes and cursor index");
    @(posedge clk);
    side <= 3'h0;
  endtask

  // refresh the word and follow it down to the intensity lines
  // how: 0 active start clears the border, 1 line blank, 2 active end
  task automatic t_video(input logic [1:0] how);
    int i;
    logic blank;
    blank = (how != 2'h0);
    @(posedge clk);
    lblank <= (how == 2'h1);
    astart <= (how == 2'h0);
    aend <= (how == 2'h2);
    @(posedge clk);
    lblank <= 1'b0;
    astart <= 1'b0;
    aend <= 1'b0;
    vg.run(rpv_pkg::MODE_REFRESH, ADR, 20'h00000);
    for (i = 0; i <= 20; i++) begin
      @(posedge clk);
      #1;
      check(pix_n, (i < 20) ? {31'h0, ~WORD[i]} : 32'h1,
            "serial");
      if (i > 0) begin
        check(inten, (WORD[i-1] && !blank) ? 4'hC : 4'h2,
              "dac");
      end
    end
  endtask

  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {lblank, astart, aend} = 3'h0;
    side = 3'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    mismatches = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_errors;
    t_readback;
    t_map;
    t_video(2'h0);
    t_video(2'h2);
    t_video(2'h0);
    t_video(2'h1);
    end_of_test;
  end
endmodule
